/* File: design/ctg_gauge.v */
// charge termination detection and gauge statistics with apb registers
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ctg_consts.vh"

// Summary of operation
// - terminate after two consecutive windows below taper
// - separate current sum per window, each compared
// - each window must gain over 0.25 mAh
// - termination sets full flag, clears charging
// - option copies full capacity into remaining
// - qualify only above charge minus taper voltage
// - start only after minimum taper capacity gained
// - window length configurable, default 40 seconds
// - taper current default 100 mA
// - full set percent minus one means taper only
// - clear full at clear percent while discharging
// - standby current tracks light loads each second
// - max load replaced by larger load currents
// - max load averaged after deep discharge full
// - cycle count steps at discharge threshold
// - discharge accumulator cleared only on cycle step
// - cycle threshold default 900 mAh
// - temperature starts at configurable 25 C default
// - seven character name at 0x63 to 0x69
// - charging only above charge current threshold
// - copy option is op config bit 4
module ctg_gauge #(
   parameter integer TICK_CYCLES = `CTG_TICK_S * `CTG_CLK_HZ,
   // arbitrary neutral value
   parameter [55:0] NAME_STR = "GAUGE01"
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [15:0] meas_current,
   input wire [15:0] meas_voltage,
   input wire [15:0] meas_dcap,
   input wire [7:0] meas_soc,
   input wire [15:0] meas_temp,
   input wire temp_valid,
   input wire [15:0] full_capacity,
   output reg full_charge_flag,
   output reg charging_flag,
   output reg remcap_load,
   output reg [15:0] remcap_value,
   output reg [15:0] standby_current,
   output reg [15:0] maxload_current,
   output reg [15:0] cycle_count,
   output reg [15:0] temperature
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WIN1 = 3'b010;
   localparam [2:0] ST_WIN2 = 3'b100;

   // configuration
   reg [15:0] opcfg_ff, chgv_ff, tapv_ff, tapi_ff, mincap_ff, chgi_ff;
   reg [15:0] deadb_ff, istby_ff, imaxl_ff, ccthr_ff, dtemp_ff;
   reg [7:0] win_ff, fcset_ff, fcclr_ff;
   // state
   reg [31:0] tick_cnt_ff;
   reg tick_ff;
   reg [2:0] state_ff;
   reg [7:0] sec_ff;
   reg signed [23:0] isum_ff, csum_ff, start_acc_ff;
   reg term_done_ff, below_half_ff, temp_seen_ff;
   reg [31:0] dacc_ff;

   // one second time base
   // one pulse per second paces the window, full flag and statistics decisions
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_ff <= 32'h00000000;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == TICK_CYCLES - 1) begin
         tick_cnt_ff <= 32'h00000000;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
         tick_ff <= 1'b0;
      end
   end

   // measurement arithmetic
   wire signed [15:0] cur_s = $signed(meas_current);
   wire signed [15:0] dcap_s = $signed(meas_dcap);
   wire signed [16:0] v_floor = $signed({1'b0, chgv_ff}) -
      $signed({1'b0, tapv_ff});
   wire volt_ok = $signed({1'b0, meas_voltage}) > v_floor;
   wire charging = cur_s > $signed(chgi_ff);
   wire discharging = cur_s < $signed(16'h0000);
   wire signed [23:0] cur_x = {{8{cur_s[15]}}, cur_s};
   wire signed [23:0] dcap_x = {{8{dcap_s[15]}}, dcap_s};
   wire signed [23:0] isum_nxt = isum_ff + cur_x;
   wire signed [23:0] csum_nxt = csum_ff + dcap_x;
   wire signed [23:0] start_nxt = start_acc_ff + dcap_x;
   wire [23:0] tap_lim_u = tapi_ff * win_ff;
   wire signed [23:0] tap_lim = $signed(tap_lim_u);
   wire win_end = (sec_ff + 8'h01) == win_ff;
   wire avg_ok = isum_nxt < tap_lim;
   wire cap_ok = csum_nxt > $signed(`CTG_WIN_CAP);
   wire start_ok = start_nxt > $signed({8'h00, mincap_ff});

   // two good windows in a row qualify termination
   reg [2:0] nxt_state;
   reg term_pulse;
   always @* begin
      nxt_state = state_ff;
      term_pulse = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (tick_ff && charging && volt_ok && !term_done_ff &&
               start_ok) begin
               nxt_state = ST_WIN1;
            end
         end
         ST_WIN1: begin
            if (tick_ff) begin
               if (!volt_ok) begin
                  nxt_state = ST_IDLE;
               end else if (win_end) begin
                  nxt_state = (avg_ok && cap_ok) ? ST_WIN2 : ST_WIN1;
               end
            end
         end
         ST_WIN2: begin
            if (tick_ff) begin
               if (!volt_ok) begin
                  nxt_state = ST_IDLE;
               end else if (win_end) begin
                  if (avg_ok && cap_ok) begin
                     nxt_state = ST_IDLE;
                     term_pulse = 1'b1;
                  end else begin
                     nxt_state = ST_WIN1;
                  end
               end
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // window accumulators
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         sec_ff <= 8'h00;
         isum_ff <= 24'h000000;
         csum_ff <= 24'h000000;
         start_acc_ff <= 24'h000000;
         term_done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (tick_ff) begin
            if (state_ff == ST_IDLE) begin
               if (charging && volt_ok && !term_done_ff) begin
                  start_acc_ff <= start_ok ? 24'h000000 : start_nxt;
               end else begin
                  start_acc_ff <= 24'h000000;
               end
            end
            if (state_ff == ST_IDLE || win_end || !volt_ok) begin
               sec_ff <= 8'h00;
               isum_ff <= 24'h000000;
               csum_ff <= 24'h000000;
            end else begin
               sec_ff <= sec_ff + 8'h01;
               isum_ff <= isum_nxt;
               csum_ff <= csum_nxt;
            end
         end
         if (term_pulse) begin
            term_done_ff <= 1'b1;
         end else if (discharging) begin
            term_done_ff <= 1'b0;
         end
      end
   end

   // flags and statistics
   wire soc_set = (fcset_ff != `CTG_FCSET_OFF) &&
      (meas_soc >= fcset_ff);
   wire soc_clr = discharging && (meas_soc <= fcclr_ff);
   // a set on the same tick beats the clear
   wire full_nxt = (term_pulse || (tick_ff && soc_set)) ? 1'b1 :
      ((tick_ff && soc_clr) ? 1'b0 : full_charge_flag);
   wire full_rise = full_nxt && !full_charge_flag;
   wire signed [16:0] ml_avg = ($signed({maxload_current[15],
      maxload_current}) + $signed({imaxl_ff[15], imaxl_ff})) >>> 1;
   wire signed [16:0] sb_lo = $signed({istby_ff, 1'b0});
   wire signed [16:0] db_neg = -$signed({1'b0, deadb_ff});
   wire [15:0] dmag = 16'h0000 - meas_dcap;
   wire [31:0] dacc_nxt = dacc_ff + {16'h0000, dmag};
   wire [31:0] cc_lim = ccthr_ff * `CTG_CAP_PER_MAH;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_charge_flag <= 1'b0;
         charging_flag <= 1'b0;
         remcap_load <= 1'b0;
         remcap_value <= 16'h0000;
         standby_current <= `CTG_RST_ISTBY;
         maxload_current <= `CTG_RST_IMAXL;
         below_half_ff <= 1'b0;
         cycle_count <= 16'h0000;
         dacc_ff <= 32'h00000000;
      end else begin
         full_charge_flag <= full_nxt;
         if (term_pulse) begin
            charging_flag <= 1'b0;
         end else begin
            charging_flag <= charging && !term_done_ff;
         end
         remcap_load <= term_pulse && opcfg_ff[`CTG_BIT_LOAD_REMCAP_FROM_FULL_CAPACITY];
         if (term_pulse && opcfg_ff[`CTG_BIT_LOAD_REMCAP_FROM_FULL_CAPACITY]) begin
            remcap_value <= full_capacity;
         end
         // light loads only: below the deadband, above twice initial
         if (tick_ff && $signed({cur_s[15], cur_s}) < db_neg &&
            $signed({cur_s[15], cur_s}) >= sb_lo) begin
            standby_current <= meas_current;
         end
         // remembers a deep discharge until the next full charge
         if (meas_soc < `CTG_HALF_SOC) begin
            below_half_ff <= 1'b1;
         end else if (full_rise) begin
            below_half_ff <= 1'b0;
         end
         if (full_rise && below_half_ff) begin
            maxload_current <= ml_avg[15:0];
         end else if (tick_ff && cur_s < $signed(imaxl_ff) &&
            cur_s < $signed(maxload_current)) begin
            maxload_current <= meas_current;
         end
         // excess over the threshold is dropped at each step
         if (tick_ff && dcap_s < $signed(16'h0000)) begin
            if (dacc_nxt >= cc_lim) begin
               cycle_count <= cycle_count + 16'h0001;
               dacc_ff <= 32'h00000000;
            end else begin
               dacc_ff <= dacc_nxt;
            end
         end
      end
   end

   // temperature holds the default until a measurement arrives
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temperature <= `CTG_RST_DTEMP;
         temp_seen_ff <= 1'b0;
      end else if (temp_valid) begin
         temperature <= meas_temp;
         temp_seen_ff <= 1'b1;
      end else if (!temp_seen_ff) begin
         temperature <= dtemp_ff;
      end
   end

   // apb decode
   wire [6:0] idx = paddr[8:2];
   wire addr_ok = (paddr[11:9] == 3'b000) && (paddr[1:0] == 2'b00);
   reg rd_hit;
   reg [15:0] rd_val;
   wire [6:0] name_sel = idx - `CTG_IDX_NAME0;
   // first character sits in the top byte of the string
   wire [55:0] name_shift = NAME_STR << {name_sel[2:0], 3'b000};
   wire [7:0] name_byte = name_shift[55:48];

   always @* begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      case (idx)
         `CTG_IDX_OPCFG: rd_val = opcfg_ff;
         `CTG_IDX_CHGV: rd_val = chgv_ff;
         `CTG_IDX_TAPV: rd_val = tapv_ff;
         `CTG_IDX_TAPI: rd_val = tapi_ff;
         `CTG_IDX_MINCAP: rd_val = mincap_ff;
         `CTG_IDX_WIN: rd_val = {8'h00, win_ff};
         `CTG_IDX_FCSET: rd_val = {8'h00, fcset_ff};
         `CTG_IDX_FCCLR: rd_val = {8'h00, fcclr_ff};
         `CTG_IDX_CHGI: rd_val = chgi_ff;
         `CTG_IDX_DEADB: rd_val = deadb_ff;
         `CTG_IDX_ISTBY: rd_val = istby_ff;
         `CTG_IDX_IMAXL: rd_val = imaxl_ff;
         `CTG_IDX_CCTHR: rd_val = ccthr_ff;
         `CTG_IDX_DTEMP: rd_val = dtemp_ff;
         `CTG_IDX_FLAGS: rd_val = {14'h0000, charging_flag,
            full_charge_flag};
         `CTG_IDX_STBY: rd_val = standby_current;
         `CTG_IDX_MAXL: rd_val = maxload_current;
         `CTG_IDX_CYCLE: rd_val = cycle_count;
         `CTG_IDX_TEMP: rd_val = temperature;
         default: begin
            if (idx >= `CTG_IDX_NAME0 && idx <= `CTG_IDX_NAME6) begin
               rd_val = {8'h00, name_byte};
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
      if (!addr_ok) begin
         rd_hit = 1'b0;
      end
   end

   // status, name and unknown addresses refuse writes
   wire wr_hit = addr_ok && (idx <= `CTG_IDX_DTEMP);
   assign pready = 1'b1;
   assign pslverr = psel && penable && (pwrite ? !wr_hit : !rd_hit);
   wire wr_en = psel && penable && pwrite && wr_hit;

   // read data is captured in setup and held through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata <= (rd_hit && !pwrite) ? {16'h0000, rd_val} :
            32'h00000000;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opcfg_ff <= `CTG_RST_OPCFG;
         chgv_ff <= `CTG_RST_CHGV;
         tapv_ff <= `CTG_RST_TAPV;
         tapi_ff <= `CTG_RST_TAPI;
         mincap_ff <= `CTG_RST_MINCAP;
         win_ff <= `CTG_RST_WIN;
         fcset_ff <= `CTG_RST_FCSET;
         fcclr_ff <= `CTG_RST_FCCLR;
         chgi_ff <= `CTG_RST_CHGI;
         deadb_ff <= `CTG_RST_DEADB;
         istby_ff <= `CTG_RST_ISTBY;
         imaxl_ff <= `CTG_RST_IMAXL;
         ccthr_ff <= `CTG_RST_CCTHR;
         dtemp_ff <= `CTG_RST_DTEMP;
      end else if (wr_en) begin
         case (idx)
            `CTG_IDX_OPCFG: opcfg_ff <= pwdata[15:0];
            `CTG_IDX_CHGV: chgv_ff <= pwdata[15:0];
            `CTG_IDX_TAPV: tapv_ff <= pwdata[15:0];
            `CTG_IDX_TAPI: tapi_ff <= pwdata[15:0];
            `CTG_IDX_MINCAP: mincap_ff <= pwdata[15:0];
            `CTG_IDX_WIN: win_ff <= pwdata[7:0];
            `CTG_IDX_FCSET: fcset_ff <= pwdata[7:0];
            `CTG_IDX_FCCLR: fcclr_ff <= pwdata[7:0];
            `CTG_IDX_CHGI: chgi_ff <= pwdata[15:0];
            `CTG_IDX_DEADB: deadb_ff <= pwdata[15:0];
            `CTG_IDX_ISTBY: istby_ff <= pwdata[15:0];
            `CTG_IDX_IMAXL: imaxl_ff <= pwdata[15:0];
            `CTG_IDX_CCTHR: ccthr_ff <= pwdata[15:0];
            `CTG_IDX_DTEMP: dtemp_ff <= pwdata[15:0];
            default: opcfg_ff <= opcfg_ff;
         endcase
      end
   end

endmodule // ctg_gauge
`default_nettype wire

/* File: design/ctg_consts.vh */
// constants for the charge termination and gauge statistics block
`ifndef CTG_CONSTS_VH
`define CTG_CONSTS_VH

// time base
`define CTG_CLK_HZ 200000000
`define CTG_TICK_S 1

// register indices, byte address is four times the index
`define CTG_IDX_OPCFG 7'h00
`define CTG_IDX_CHGV 7'h01
`define CTG_IDX_TAPV 7'h02
`define CTG_IDX_TAPI 7'h03
`define CTG_IDX_MINCAP 7'h04
`define CTG_IDX_WIN 7'h05
`define CTG_IDX_FCSET 7'h06
`define CTG_IDX_FCCLR 7'h07
`define CTG_IDX_CHGI 7'h08
`define CTG_IDX_DEADB 7'h09
`define CTG_IDX_ISTBY 7'h0A
`define CTG_IDX_IMAXL 7'h0B
`define CTG_IDX_CCTHR 7'h0C
`define CTG_IDX_DTEMP 7'h0D
`define CTG_IDX_FLAGS 7'h10
`define CTG_IDX_STBY 7'h11
`define CTG_IDX_MAXL 7'h12
`define CTG_IDX_CYCLE 7'h13
`define CTG_IDX_TEMP 7'h14
`define CTG_IDX_NAME0 7'h63
`define CTG_IDX_NAME6 7'h69

// field positions
`define CTG_BIT_LOAD_REMCAP_FROM_FULL_CAPACITY 4
`define CTG_BIT_FULL 0
`define CTG_BIT_CHG 1

// reset values
`define CTG_RST_OPCFG 16'h0010
`define CTG_RST_CHGV 16'h1068
`define CTG_RST_TAPV 16'h0064
`define CTG_RST_TAPI 16'h0064
`define CTG_RST_MINCAP 16'h0019
`define CTG_RST_WIN 8'h28
`define CTG_RST_FCSET 8'h63
`define CTG_RST_FCCLR 8'h62
`define CTG_RST_CHGI 16'h0032
`define CTG_RST_DEADB 16'h0005
`define CTG_RST_ISTBY 16'hFFF6
`define CTG_RST_IMAXL 16'hFE0C
`define CTG_RST_CCTHR 16'h0384
`define CTG_RST_DTEMP 16'h0019

// fixed figures
`define CTG_FCSET_OFF 8'hFF
`define CTG_WIN_CAP 24'h000019
`define CTG_HALF_SOC 8'h32
`define CTG_CAP_PER_MAH 16'h0064

`endif

/* File: sim/ctg_gauge_monitor.sv */
// port checker for the charge termination and gauge statistics block
`timescale 1ns/1ps
`default_nettype none
module ctg_gauge_monitor (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire pslverr,
   input wire [15:0] meas_current,
   input wire [15:0] meas_temp,
   input wire temp_valid,
   input wire full_charge_flag,
   input wire charging_flag,
   input wire remcap_load,
   input wire [15:0] standby_current,
   input wire [15:0] maxload_current,
   input wire [15:0] cycle_count,
   input wire [15:0] temperature
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire name_wr;
   assign name_wr = psel && penable && pwrite && paddr[11:2] >= 10'h063
      && paddr[11:2] <= 10'h069;
   copy_pulse_a: assert property (remcap_load |=> !remcap_load)
      else $error("copy pulse too long");
   term_flags_a: assert property (
      remcap_load |-> full_charge_flag && !charging_flag)
      else $error("flags wrong at termination");
   cycle_step_a: assert property (
      $changed(cycle_count) |-> cycle_count == $past(cycle_count) + 16'h0001)
      else $error("cycle count step wrong");
   temp_load_a: assert property (
      temp_valid |=> temperature == $past(meas_temp))
      else $error("temperature not loaded");
   standby_win_a: assert property (
      $changed(standby_current) |-> $signed(standby_current) <
      $signed(16'hFFFB) && $signed(standby_current) >= $signed(16'hFFEC))
      else $error("standby outside window");
   maxload_dec_a: assert property (
      $changed(maxload_current) && !full_charge_flag |->
      $signed(maxload_current) < $signed($past(maxload_current)))
      else $error("maxload not a larger load");
   chg_rise_a: assert property (
      $rose(charging_flag) |-> $signed($past(meas_current)) >
      $signed(16'h0032) || $signed($past(meas_current, 2)) > $signed(16'h0032))
      else $error("charging without current");
   name_ro_a: assert property (name_wr |-> pslverr)
      else $error("name write accepted");
   cover property (remcap_load);
   cover property ($changed(cycle_count));
   cover property ($fell(full_charge_flag));
   cover property ($rose(full_charge_flag) && !remcap_load);
endmodule // ctg_gauge_monitor
bind ctg_gauge ctg_gauge_monitor mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pslverr(pslverr), .meas_current(meas_current), .meas_temp(meas_temp),
   .temp_valid(temp_valid), .full_charge_flag(full_charge_flag),
   .charging_flag(charging_flag), .remcap_load(remcap_load),
   .standby_current(standby_current), .maxload_current(maxload_current),
   .cycle_count(cycle_count), .temperature(temperature));
`default_nettype wire

/* File: sim/ctg_host_model.sv */
// apb host model issuing register transfers to the gauge
`timescale 1ns/1ps
`default_nettype none
module ctg_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [6:0] k,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {3'h0, k, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines do not keep the last value
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule // ctg_host_model
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the charge termination and gauge block
`timescale 1ns/1ps
`default_nettype none
`include "ctg_consts.vh"
module tb;
   localparam integer TK = 20;
   // arbitrary name string
   localparam [55:0] NM = "TSTNAME";
   localparam logic [15:0] RST [14] = '{`CTG_RST_OPCFG, `CTG_RST_CHGV,
      `CTG_RST_TAPV, `CTG_RST_TAPI, `CTG_RST_MINCAP, `CTG_RST_WIN,
      `CTG_RST_FCSET, `CTG_RST_FCCLR, `CTG_RST_CHGI, `CTG_RST_DEADB,
      `CTG_RST_ISTBY, `CTG_RST_IMAXL, `CTG_RST_CCTHR, `CTG_RST_DTEMP};
   logic pclk, presetn, tv, e;
   logic [7:0] soc;
   logic [15:0] im, vm, dc, tin, fcap, es;
   logic [31:0] seed, q;
   int fails, cmp_count, cycles, n;
   wire psel, penable, pwrite, pready, pslverr, ff, cf, rl;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [15:0] rv, sb, ml, cc, tp;
   ctg_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   ctg_gauge #(.TICK_CYCLES(TK), .NAME_STR(NM)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .meas_current(im), .meas_voltage(vm),
      .meas_dcap(dc), .meas_soc(soc), .meas_temp(tin), .temp_valid(tv),
      .full_capacity(fcap), .full_charge_flag(ff), .charging_flag(cf),
      .remcap_load(rl), .remcap_value(rv), .standby_current(sb),
      .maxload_current(ml), .cycle_count(cc), .temperature(tp));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // standby follows light loads between deadband and twice initial
   function automatic logic [15:0] exp_stby(input logic [15:0] p, i);
      return ($signed(i) < $signed(16'hFFFB) &&
         $signed(i) >= $signed(16'hFFEC)) ? i : p;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (fails == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [6:0] k, input logic [31:0] d);
      host.xfer(1'b1, k, d, q, e);
   endtask
   task automatic meas(input logic [15:0] i, v, d);
      @(posedge pclk);
      im <= i;
      vm <= v;
      dc <= d;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         end_sim;
      end
   end
   initial begin
      presetn = 1'b0;
      tv = 1'b0;
      soc = 8'h3C;
      seed = 32'h6FE998AF;
      fcap = seed[15:0];
      im = 16'h0000;
      vm = 16'h0E10;
      dc = 16'h0000;
      tin = 16'h0000;
      es = 16'hFFF6;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({sb, ml}, 32'hFFF6FE0C);
      chk({cc, tp}, 32'h00000019);
      for (int k = 0; k < 14; k++) begin
         host.xfer(1'b0, 7'(k), 32'h0, q, e);
         chk(q, 32'(RST[k]));
      end
      for (int k = 0; k < 7; k++) begin
         host.xfer(1'b0, 7'h63 + 7'(k), 32'h0, q, e);
         chk(q, {24'h0, NM[55 - 8 * k -: 8]});
      end
      wr(7'h63, 32'h00000041);
      chk({31'h0, e}, 32'h1);
      host.xfer(1'b0, 7'h30, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h80000000);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         @(posedge pclk);
         tin <= seed[15:0];
         tv <= 1'b1;
         @(posedge pclk);
         tv <= 1'b0;
         @(posedge pclk);
         chk(32'(tp), 32'(seed[15:0]));
      end
      wr(7'h05, 32'h2);
      wr(7'h06, 32'hFF);
      meas(16'h003C, 16'h1068, 16'h000A);
      repeat (10 * TK) @(posedge pclk);
      chk({30'h0, cf, ff}, 32'h2);
      meas(16'h003C, 16'h1004, 16'h001E);
      repeat (10 * TK) @(posedge pclk);
      chk({31'h0, ff}, 32'h0);
      meas(16'h0065, 16'h1068, 16'h001E);
      repeat (10 * TK) @(posedge pclk);
      chk({31'h0, ff}, 32'h0);
      meas(16'h0063, 16'h1068, 16'h001E);
      n = 0;
      while (rl !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk({29'h0, rl, cf, ff}, 32'h5);
      chk(32'(rv), 32'(fcap));
      meas(16'hFDA8, 16'h0E10, 16'h0000);
      repeat (3 * TK) @(posedge pclk);
      chk({15'h0, ff, ml}, 32'h0000FDA8);
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         meas(16'hFFFA - 16'(seed[3:0]), 16'h0E10, 16'h0000);
         repeat (2 * TK) @(posedge pclk);
         es = exp_stby(es, im);
         chk(32'(sb), 32'(es));
      end
      wr(7'h0C, 32'h1);
      meas(16'hFFF6, 16'h0E10, 16'hFFCE);
      n = 0;
      while (cc === 16'h0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      meas(16'hFFF6, 16'h0E10, 16'h0000);
      chk(32'(cc), 32'h1);
      // deep discharge, then full by percentage averages the max load with its initial value
      soc <= 8'h28;
      meas(16'h0000, 16'h0E10, 16'h0000);
      wr(7'h06, 32'h50);
      soc <= 8'h5A;
      repeat (2 * TK) @(posedge pclk);
      chk({15'h0, ff, ml}, 32'h0001FDDA);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({cc, tp}, 32'h00000019);
      end_sim;
   end
endmodule // tb
`default_nettype wire
